// File: rtl/dac_ctrl_defs.svh
/*
 register offsets, field positions, reset values and widths of the
 two-channel converter control block.
 assumes: included by bare name from the top, the data register and the testbench.
*/
`ifndef DAC_CTRL_DEFS_SVH
`define DAC_CTRL_DEFS_SVH

// ============================================================
// register byte addresses (index times four)
// ============================================================
`define CONV_VALUE_CH0_IDX  8'hf8
`define CONV_VALUE_CH1_IDX  8'hf9
`define CONV_CTRL_IDX       8'hfa
`define CONV_STATUS_IDX     8'hfb
`define ADDR_W              12
`define CONV_VALUE_CH0_ADDR 12'h3e0
`define CONV_VALUE_CH1_ADDR 12'h3e4
`define CONV_CTRL_ADDR      12'h3e8
`define CONV_STATUS_ADDR    12'h3ec

// ============================================================
// control register fields
// ============================================================
`define CTRL_OUT1_EN_BIT    7
`define CTRL_OUT0_EN_BIT    6
`define CTRL_COMMON_EN_BIT  5
`define CTRL_RESET_VAL      8'h1f
`define CTRL_RESERVED_MASK  8'h1f

// ============================================================
// data registers
// ============================================================
`define CONV_DATA_W         8
`define CONV_DATA_RESET     8'h00

// ============================================================
// bus answers
// ============================================================
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// File: rtl/dac_ctrl_pkg.sv
/*
 types shared by the converter control block.
 assumes: dac_ctrl_defs.svh holds all numeric constants.
*/
package dac_ctrl_pkg;
   // ============================================================
   // slave channel states
   // ============================================================
   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,  // waiting for address and data
      WR_RESP = 2'b01   // response offered
   } wr_state_t;

   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,  // waiting for address
      RD_DATA = 2'b01   // read data offered
   } rd_state_t;
endpackage

// File: rtl/dac_ctrl_top.sv
/*
 two-channel converter control: axi4-lite slave with two data
 registers, a control register and a status register; drives
 converter cores with data, conversion enable and output enable.
 assumes: single 125 MHz clock, synchronous active-high reset, master
 keeps at most one write and one read outstanding.
*/
// How it works
// - both output enables clear: both channels off
// - only channel 0 enable: channel 0 on
// - only channel 1 enable: channel 1 on
// - both enables, or one plus common: both on
// - channel 0 enable drives pin 0 output
// - channel 1 enable drives pin 1 output
// - eight-bit read/write data registers, reset zero
`timescale 1ns/100ps
`include "dac_ctrl_defs.svh"
module dac_ctrl_top
   import dac_ctrl_pkg::*;
(
   input  wire logic        SYS_CLK_I,     // system clock
   input  wire logic        RST_I,         // synchronous reset
   input  wire logic [11:0] AWADDR_I,      // write address
   input  wire logic        AWVALID_I,     // write address valid
   output logic             AWREADY_O,     // write address ready
   input  wire logic [31:0] WDATA_I,       // write data
   input  wire logic [3:0]  WSTRB_I,       // write byte strobes
   input  wire logic        WVALID_I,      // write data valid
   output logic             WREADY_O,      // write data ready
   output logic [1:0]       BRESP_O,       // write response
   output logic             BVALID_O,      // write response valid
   input  wire logic        BREADY_I,      // write response ready
   input  wire logic [11:0] ARADDR_I,      // read address
   input  wire logic        ARVALID_I,     // read address valid
   output logic             ARREADY_O,     // read address ready
   output logic [31:0]      RDATA_O,       // read data
   output logic [1:0]       RRESP_O,       // read response
   output logic             RVALID_O,      // read data valid
   input  wire logic        RREADY_I,      // read data ready
   output logic [7:0]       CONV_VALUE0_O, // channel 0 core data
   output logic [7:0]       CONV_VALUE1_O, // channel 1 core data
   output logic             CONV_EN0_O,    // channel 0 conversion enable
   output logic             CONV_EN1_O,    // channel 1 conversion enable
   output logic             ANALOG_PIN0_OE_O, // drive analog_pin0
   output logic             ANALOG_PIN1_OE_O  // drive analog_pin1
);
   // ============================================================
   // decode helper
   // ============================================================
   // known register address check, used by both channels
   function automatic logic addr_known(input logic [11:0] a);
      addr_known = (a == `CONV_VALUE_CH0_ADDR) || (a == `CONV_VALUE_CH1_ADDR) ||
                   (a == `CONV_CTRL_ADDR) || (a == `CONV_STATUS_ADDR);
   endfunction

   // ============================================================
   // write channel state
   // ============================================================
   wr_state_t   wr_state_reg, wr_state_next;  // write channel state
   logic        aw_have_reg, aw_have_next;    // address captured
   logic        w_have_reg, w_have_next;      // data captured
   logic [11:0] awaddr_reg, awaddr_next;      // captured address
   logic [7:0]  wbyte_reg, wbyte_next;        // captured low byte
   logic        wstrb0_reg, wstrb0_next;      // low lane strobe
   logic [1:0]  bresp_reg, bresp_next;        // write answer
   logic        wr_fire;                      // perform write now
   logic [7:0]  ctrl_reg, ctrl_next;          // control register
   logic        wr_ch0, wr_ch1;               // data register strobes

   assign AWREADY_O = (wr_state_reg == WR_IDLE) && !aw_have_reg;
   assign WREADY_O  = (wr_state_reg == WR_IDLE) && !w_have_reg;
   assign BVALID_O  = (wr_state_reg == WR_RESP);
   assign BRESP_O   = bresp_reg;

   // next values of the write path
   always_comb begin
      logic aw_ok;
      logic w_ok;
      aw_ok         = AWVALID_I && AWREADY_O;
      w_ok          = WVALID_I && WREADY_O;
      wr_state_next = wr_state_reg;
      aw_have_next  = aw_have_reg;
      w_have_next   = w_have_reg;
      awaddr_next   = awaddr_reg;
      wbyte_next    = wbyte_reg;
      wstrb0_next   = wstrb0_reg;
      bresp_next    = bresp_reg;
      ctrl_next     = ctrl_reg;
      wr_fire       = 1'b0;
      case (wr_state_reg)
         WR_IDLE: begin
            if (aw_ok) begin
               aw_have_next = 1'b1;
               awaddr_next  = AWADDR_I;
            end
            if (w_ok) begin
               w_have_next = 1'b1;
               wbyte_next  = WDATA_I[7:0];
               wstrb0_next = WSTRB_I[0];
            end
            // both halves present: commit in this cycle
            if (aw_have_reg && w_have_reg) begin
               wr_fire       = 1'b1;
               aw_have_next  = 1'b0;
               w_have_next   = 1'b0;
               bresp_next    = addr_known(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
               wr_state_next = WR_RESP;
               if (wstrb0_reg && awaddr_reg == `CONV_CTRL_ADDR) begin
                  ctrl_next = wbyte_reg | `CTRL_RESERVED_MASK;
               end
            end
         end
         WR_RESP: begin
            if (BREADY_I) begin
               wr_state_next = WR_IDLE;
            end
         end
         default: begin
            wr_state_next = WR_IDLE;
         end
      endcase
   end

   // write path registers
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         wr_state_reg <= WR_IDLE;
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         awaddr_reg   <= 12'h000;
         wbyte_reg    <= 8'h00;
         wstrb0_reg   <= 1'b0;
         bresp_reg    <= `RESP_OKAY;
         ctrl_reg     <= `CTRL_RESET_VAL;
      end else begin
         wr_state_reg <= wr_state_next;
         aw_have_reg  <= aw_have_next;
         w_have_reg   <= w_have_next;
         awaddr_reg   <= awaddr_next;
         wbyte_reg    <= wbyte_next;
         wstrb0_reg   <= wstrb0_next;
         bresp_reg    <= bresp_next;
         ctrl_reg     <= ctrl_next;
      end
   end

   assign wr_ch0 = wr_fire && wstrb0_reg && (awaddr_reg == `CONV_VALUE_CH0_ADDR);
   assign wr_ch1 = wr_fire && wstrb0_reg && (awaddr_reg == `CONV_VALUE_CH1_ADDR);

   // ============================================================
   // data registers and enable decode
   // ============================================================
   logic [7:0] value0, value1;    // held channel values
   logic [1:0] conv_en;           // decoded conversion enables
   logic [1:0] en_reg, en_next;   // registered enables

   dac_data_reg #(.DATA_W(`CONV_DATA_W)) ch0_data (
      .clk_i   (SYS_CLK_I),
      .rst_i   (RST_I),
      .wr_i    (wr_ch0),
      .wdata_i (wbyte_reg),
      .value_o (value0)
   );

   dac_data_reg #(.DATA_W(`CONV_DATA_W)) ch1_data (
      .clk_i   (SYS_CLK_I),
      .rst_i   (RST_I),
      .wr_i    (wr_ch1),
      .wdata_i (wbyte_reg),
      .value_o (value1)
   );

   dac_enable_decode enables (
      .out0_en_i   (ctrl_reg[`CTRL_OUT0_EN_BIT]),
      .out1_en_i   (ctrl_reg[`CTRL_OUT1_EN_BIT]),
      .common_en_i (ctrl_reg[`CTRL_COMMON_EN_BIT]),
      .conv_en_o   (conv_en)
   );

   // enable register next value
   always_comb begin
      en_next = conv_en;
   end

   // enable register
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         en_reg <= 2'b00;
      end else begin
         en_reg <= en_next;
      end
   end

   assign CONV_VALUE0_O    = value0;
   assign CONV_VALUE1_O    = value1;
   assign CONV_EN0_O       = en_reg[0];
   assign CONV_EN1_O       = en_reg[1];
   assign ANALOG_PIN0_OE_O = ~ctrl_reg[`CTRL_OUT0_EN_BIT];  // low drives
   assign ANALOG_PIN1_OE_O = ~ctrl_reg[`CTRL_OUT1_EN_BIT];  // low drives

   // ============================================================
   // read channel
   // ============================================================
   rd_state_t   rd_state_reg, rd_state_next;  // read channel state
   logic [31:0] rdata_reg, rdata_next;        // read data
   logic [1:0]  rresp_reg, rresp_next;        // read answer

   assign ARREADY_O = (rd_state_reg == RD_IDLE);
   assign RVALID_O  = (rd_state_reg == RD_DATA);
   assign RDATA_O   = rdata_reg;
   assign RRESP_O   = rresp_reg;

   // read next values
   always_comb begin
      rd_state_next = rd_state_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      case (rd_state_reg)
         RD_IDLE: begin
            if (ARVALID_I) begin
               rd_state_next = RD_DATA;
               rresp_next    = addr_known(ARADDR_I) ? `RESP_OKAY : `RESP_SLVERR;
               case (ARADDR_I)
                  `CONV_VALUE_CH0_ADDR: rdata_next = {24'h000000, value0};
                  `CONV_VALUE_CH1_ADDR: rdata_next = {24'h000000, value1};
                  `CONV_CTRL_ADDR:      rdata_next = {24'h000000, ctrl_reg};
                  `CONV_STATUS_ADDR:    rdata_next = {30'h0, en_reg};
                  default:              rdata_next = 32'h00000000;
               endcase
            end
         end
         RD_DATA: begin
            if (RREADY_I) begin
               rd_state_next = RD_IDLE;
            end
         end
         default: begin
            rd_state_next = RD_IDLE;
         end
      endcase
   end

   // read registers
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         rd_state_reg <= RD_IDLE;
         rdata_reg    <= 32'h00000000;
         rresp_reg    <= `RESP_OKAY;
      end else begin
         rd_state_reg <= rd_state_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
      end
   end

   // ============================================================
   // checks
   // ============================================================
   both_off_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (!ctrl_reg[`CTRL_OUT0_EN_BIT] && !ctrl_reg[`CTRL_OUT1_EN_BIT])
      |=> (!CONV_EN0_O && !CONV_EN1_O))
      else $error("channels on with both enables clear");
   only_ch0_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (ctrl_reg[7:5] == 3'b010) |=> (CONV_EN0_O && !CONV_EN1_O))
      else $error("channel 0 only case wrong");
   only_ch1_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (ctrl_reg[7:5] == 3'b100) |=> (!CONV_EN0_O && CONV_EN1_O))
      else $error("channel 1 only case wrong");
   both_on_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      ((ctrl_reg[7] && ctrl_reg[6]) || ((ctrl_reg[7] ^ ctrl_reg[6]) && ctrl_reg[5]))
      |=> (CONV_EN0_O && CONV_EN1_O))
      else $error("both channels not enabled");
   // pin drive follows its enable bit at once,
   // the conversion enable one edge later
   pin0_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (ANALOG_PIN0_OE_O == !ctrl_reg[`CTRL_OUT0_EN_BIT]) and
      ($rose(ctrl_reg[`CTRL_OUT0_EN_BIT]) |=> CONV_EN0_O))
      else $error("pin 0 drive wrong");
   pin1_drive_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (ANALOG_PIN1_OE_O == !ctrl_reg[`CTRL_OUT1_EN_BIT]) and
      ($rose(ctrl_reg[`CTRL_OUT1_EN_BIT]) |=> CONV_EN1_O))
      else $error("pin 1 drive wrong");
   data_write_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      wr_ch1 |=> (CONV_VALUE1_O == $past(wbyte_reg)))
      else $error("channel 1 value not stored");
   data_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      (!wr_ch0 && !RST_I) |=> $stable(CONV_VALUE0_O))
      else $error("channel 0 value changed without write");
   data_write0_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      wr_ch0 |=> (CONV_VALUE0_O == $past(wbyte_reg)))
      else $error("channel 0 value not stored");
   data_hold1_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      !wr_ch1 |=> $stable(CONV_VALUE1_O))
      else $error("channel 1 value changed without write");
   // data registers leave reset at zero
   reset_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
      $fell(RST_I) |-> (CONV_VALUE0_O == 8'h00 && CONV_VALUE1_O == 8'h00))
      else $error("data registers not cleared by reset");
endmodule

// File: rtl/dac_data_reg.sv
/*
 one channel's converter data register with byte write.
 assumes: write strobe and data from the bus slave on the same clock.
*/
`timescale 1ns/100ps
`include "dac_ctrl_defs.svh"
module dac_data_reg #(
   parameter int DATA_W = `CONV_DATA_W
) (
   input  wire logic              clk_i,   // system clock
   input  wire logic              rst_i,   // synchronous reset
   input  wire logic              wr_i,    // write this register
   input  wire logic [DATA_W-1:0] wdata_i, // value written
   output logic      [DATA_W-1:0] value_o  // held value
);
   logic [DATA_W-1:0] value_reg;   // stored value
   logic [DATA_W-1:0] value_next;  // next stored value

   // refuse, at elaboration, widths that the read word cannot carry
   if (DATA_W < 1 || DATA_W > 32) begin : g_width_bad
      $error("data width out of range");
   end

   // ============================================================
   // next value
   // ============================================================
   always_comb begin
      value_next = value_reg;
      if (wr_i) begin
         value_next = wdata_i;
      end
   end

   // ============================================================
   // storage
   // ============================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         value_reg <= DATA_W'(`CONV_DATA_RESET);
      end else begin
         value_reg <= value_next;
      end
   end

   assign value_o = value_reg;
endmodule

// File: rtl/dac_enable_decode.sv
/*
 decodes the three control bits into per-channel conversion enables.
 assumes: inputs come from registers on the same clock; output is
 combinational and registered by the caller.
*/
`timescale 1ns/100ps
module dac_enable_decode (
   input  wire logic       out0_en_i,    // channel 0 output enable
   input  wire logic       out1_en_i,    // channel 1 output enable
   input  wire logic       common_en_i,  // common converter enable
   output logic      [1:0] conv_en_o     // conversion enable per channel
);
   // ============================================================
   // decode table
   // ============================================================
   always_comb begin
      conv_en_o = 2'b00;
      if (out0_en_i && out1_en_i) begin
         conv_en_o = 2'b11;
      end else if (out0_en_i || out1_en_i) begin
         if (common_en_i) begin
            conv_en_o = 2'b11;
         end else begin
            conv_en_o = {out1_en_i, out0_en_i};
         end
      end else begin
         conv_en_o = 2'b00;
      end
   end
endmodule

// File: testbench/test_dual_dac_enable_control.sv
/*
 self-checking bench for the two-channel converter control block:
 bus tasks, expected answers queued, a monitor comparing them.
 assumes: rtl/ package and modules compiled first; one 125 MHz clock.
*/
`timescale 1ns/100ps
`include "dac_ctrl_defs.svh"
module test_dual_dac_enable_control;
   // ============================================================
   // signals
   // ============================================================
   logic        clk;                  // system clock
   logic        rst;                  // synchronous reset
   logic [11:0] awaddr, araddr;       // bus addresses
   logic        awvalid, wvalid;      // write requests
   logic        bready, arvalid;      // response ready, read request
   logic        rready;               // read data ready
   logic [31:0] wdata;                // write data
   logic [3:0]  wstrb;                // byte strobes
   logic        awready, wready;      // write readies
   logic        bvalid, arready;      // write answer, read ready
   logic        rvalid;               // read answer
   logic [1:0]  bresp, rresp;         // response codes
   logic [31:0] rdata;                // read data
   logic [7:0]  val0, val1;           // core data
   logic        en0, en1;             // conversion enables
   logic        oe0_n, oe1_n;         // pin drive, low = driven
   int          n_fail;               // mismatches
   int          total_checks;         // comparisons made
   logic [31:0] seed;                 // xorshift state
   logic [1:0]  bq[$];                // expected write answers
   logic [33:0] rq[$];                // expected read answers

   dac_ctrl_top uut (.SYS_CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid),
      .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
      .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
      .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .CONV_VALUE0_O(val0),
      .CONV_VALUE1_O(val1), .CONV_EN0_O(en0), .CONV_EN1_O(en1),
      .ANALOG_PIN0_OE_O(oe0_n), .ANALOG_PIN1_OE_O(oe1_n));

   // ============================================================
   // clock
   // ============================================================
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ============================================================
   // helpers
   // ============================================================
   // next pseudo-random word
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // compare a bus answer
   task automatic chk_word(input string what, input logic [33:0] exp, input logic [33:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // compare a level output
   task automatic chk_bit(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask

   // verdict and end of run
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ============================================================
   // bus master tasks
   // ============================================================
   // one write, address and data offered together
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] er);
      logic a_ok, w_ok;
      bq.push_back(er);
      a_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      // wait as long as it takes: only the watchdog ends a hang
      do begin
         @(posedge clk);
         if (awvalid === 1'b1 && awready === 1'b1) a_ok = 1'b1;
         if (wvalid === 1'b1 && wready === 1'b1) w_ok = 1'b1;
         if (a_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end while (!(a_ok && w_ok));
      bready <= 1'b1;
      do begin
         @(posedge clk);
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask

   // one read
   task automatic rd(input logic [11:0] a, input logic [1:0] er, input logic [31:0] ed);
      rq.push_back({er, ed});
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge clk);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask

   // ============================================================
   // monitor: answers against the oldest note
   // ============================================================
   always @(posedge clk) begin
      if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) begin
         chk_word("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
      end
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
         chk_word("rdata", rq.pop_front(), {rresp, rdata});
      end
   end

   // ============================================================
   // watchdog
   // ============================================================
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("BAD watchdog expected end seen hang");
      stop_test();
   end

   // ============================================================
   // main sequence
   // ============================================================
   initial begin
      logic [7:0]  ctl;
      logic        e0, e1;
      logic [31:0] r;
      rst = 1'b1;
      {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
      wdata = 32'h0;
      wstrb = 4'h0;
      n_fail = 0;
      total_checks = 0;
      seed = 32'h10ad4726;
      for (int p = 0; p < 2; p++) begin
         rst <= 1'b1;
         repeat (8) @(posedge clk);
         rst <= 1'b0;
         // reset state, also after a mid-run reset
         rd(`CONV_VALUE_CH0_ADDR, `RESP_OKAY, 32'h0);
         rd(`CONV_VALUE_CH1_ADDR, `RESP_OKAY, 32'h0);
         rd(`CONV_CTRL_ADDR, `RESP_OKAY, 32'h1f);
         chk_bit("en0", 1'b0, en0);
         chk_bit("en1", 1'b0, en1);
         chk_bit("oe0_n", 1'b1, oe0_n);
         chk_bit("oe1_n", 1'b1, oe1_n);
         chk_word("val0", 34'h0, {26'h0, val0});
         $display("reset test done pass %0d", p);
         if (p == 1) break;
         // every combination of the three enable bits
         for (int c = 0; c < 8; c++) begin
            ctl = {c[2:0], 5'h0};
            e0 = ctl[6] | (ctl[7] & ctl[5]);
            e1 = ctl[7] | (ctl[6] & ctl[5]);
            wr(`CONV_CTRL_ADDR, {xs(seed + c) & 32'hffffff00} | ctl, 4'h1, `RESP_OKAY);
            repeat (2) @(posedge clk);
            chk_bit("en0", e0, en0);
            chk_bit("en1", e1, en1);
            chk_bit("oe0_n", ~ctl[6], oe0_n);
            chk_bit("oe1_n", ~ctl[7], oe1_n);
            rd(`CONV_CTRL_ADDR, `RESP_OKAY, {24'h0, ctl[7:5], 5'h1f});
            rd(`CONV_STATUS_ADDR, `RESP_OKAY, {30'h0, e1, e0});
         end
         $display("enable decode test done");
         // data registers, back to back with random values
         for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            r = seed;
            wr(`CONV_VALUE_CH0_ADDR, r, 4'h1, `RESP_OKAY);
            chk_word("val0", {26'h0, r[7:0]}, {26'h0, val0});
            wr(`CONV_VALUE_CH1_ADDR, ~r, 4'h1, `RESP_OKAY);
            chk_word("val1", {26'h0, ~r[7:0]}, {26'h0, val1});
            rd(`CONV_VALUE_CH0_ADDR, `RESP_OKAY, {24'h0, r[7:0]});
            rd(`CONV_VALUE_CH1_ADDR, `RESP_OKAY, {24'h0, ~r[7:0]});
         end
         // lane 0 strobe clear and unmapped place leave data alone
         wr(`CONV_VALUE_CH0_ADDR, 32'h5a, 4'he, `RESP_OKAY);
         wr(12'h3f0, 32'ha5, 4'h1, `RESP_SLVERR);
         rd(12'h3f0, `RESP_SLVERR, 32'h0);
         chk_word("val0", {26'h0, r[7:0]}, {26'h0, val0});
         $display("data register test done");
      end
      repeat (4) @(posedge clk);
      stop_test();
   end
endmodule
